// file: design/ccm_regs.svh
// Register offsets, field positions, reset values and timing counts of the capture/compare unit
`ifndef CCM_REGS_SVH
`define CCM_REGS_SVH
`define CCM_ADDR_W      6
`define CCM_CC_BASE     6'h00
`define CCM_MODE_BASE   6'h10
`define CCM_TMR_BASE    6'h20
`define CCM_TMR_STRIDE  6'h03
`define CCM_TMR_CTRL    6'h00
`define CCM_TMR_CNT     6'h01
`define CCM_TMR_REL     6'h02
`define CCM_GCTRL       6'h26
`define CCM_IRQ_STAT    6'h27
`define CCM_IRQ_MASK    6'h28
`define CCM_PIN_STAT    6'h29
`define CCM_TCTL_RUN    0
`define CCM_TCTL_CLK    1
`define CCM_GCTL_STAG   0
`define CCM_RST_WORD    16'h0000
`define CCM_RST_CFG     6'h00
`define CCM_STAG_LAST   3'h7
`define CCM_CNT_TOP     16'hFFFF
`define CCM_CLK_T6      3'h6
`define CCM_CLK_EXT     3'h7
`endif

// file: design/ccm_pkg.sv
// Types shared by the capture/compare unit and its users
package ccm_pkg;
   typedef enum logic [2:0] {
      CCM_OFF      = 3'h0,
      CCM_CAP_RISE = 3'h1,
      CCM_CAP_FALL = 3'h2,
      CCM_CAP_BOTH = 3'h3,
      CCM_CMP0     = 3'h4,
      CCM_CMP1     = 3'h5,
      CCM_CMP2     = 3'h6,
      CCM_CMP3     = 3'h7
   } ccm_mode_t;

   // Channel configuration word, bits [5:0]
   typedef struct packed {
      logic      dbl;
      logic      single;
      logic      tsel;
      ccm_mode_t mode;
   } ccm_cfg_t;

   // Register port request from software
   typedef struct packed {
      logic [5:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } ccm_bus_req_t;
endpackage

// file: design/ccm_unit.sv
// Sixteen-channel capture/compare unit with two reloadable time bases
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ccm_regs.svh"

// Function
// - Sixteen channels, one-clock resolution normally
// - Staggered mode: prescaled timers step only on every eighth clock
// - Two 16-bit timers with reload registers
// - Timer clock: prescaled clock or timer-six overflow
// - External count inputs can clock timers
// - Each channel picks timer and capture/compare
// - One pin per channel, input or output
// - Capture copies allocated timer on pin event
// - Every capture raises channel interrupt
// - Capture edge: rising, falling or both
// - Compare channels match timer, act per mode
// - Mode 0: interrupt only, pin untouched
// - Mode 1: pin toggles on every match
// - Mode 2: interrupt once per timer period
// - Mode 3: pin high on match, low overflow
// - Double mode: two registers toggle one pin
// - Single event option disables after one event
module ccm_unit #(
   parameter int NCH = 16                         // Channel count
) (
   input  wire logic                 clk,         // System clock, 40 MHz
   input  wire logic                 reset,       // Synchronous, active high
   input  wire ccm_pkg::ccm_bus_req_t busReq,     // Register request
   output logic [15:0]               rdata,       // Read data, cycle after read
   input  wire logic [NCH-1:0]       pinIn,       // Channel pin levels
   output logic [NCH-1:0]            pinOut,      // Channel pin drive levels
   output logic [NCH-1:0]            pinOe,       // Channel pin drive enables
   input  wire logic                 genTimerSixOvf, // Timer-six overflow pulse
   input  wire logic [1:0]           extCount,    // External count inputs
   output logic                      irq          // Level interrupt
);
   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   ccm_pkg::ccm_cfg_t cfg_r [NCH];
   logic [15:0]       ccVal_r [NCH];
   logic [15:0]       chCnt [NCH];
   logic [NCH-1:0]    pinPrev_r, armed_r, capEvt, cmpMatch, pinOut_r, pinOe_r;
   logic [NCH-1:0]    irqStat_r, irqMask_r, irqClr;
   logic [15:0]       tmrCnt_r [2];
   logic [15:0]       tmrRel_r [2];
   logic [3:0]        tmrCtl_r [2];
   logic [1:0]        tmrTick, tmrStep_r, ovf_r, extPrev_r;
   logic [7:0]        presc_r;
   logic [2:0]        stagCnt_r;
   logic              stag_r, stagOk, irq_r;
   logic [15:0]       rdata_r, rdata_nxt;

   // Elaboration check: pairs i and i+NCH/2 need an even count up to 16
   if (NCH < 2 || NCH > 16 || NCH % 2 != 0) begin : g_bad_nch
      $error("NCH must be even, 2 to 16");
   end

   function automatic logic wrHit(input ccm_pkg::ccm_bus_req_t r, input logic [5:0] a);
      return r.wr && r.addr == a;
   endfunction

   // ---------------------------------------------------------------
   // Prescaler and stagger slot
   // ---------------------------------------------------------------
   // Free-running prescaler and eight-slot stagger counter
   always_ff @(posedge clk) begin
      if (reset) begin
         presc_r   <= 8'h00;
         stagCnt_r <= 3'h0;
      end else begin
         presc_r   <= presc_r + 8'h01;
         stagCnt_r <= stagCnt_r + 3'h1;
      end
   end
   assign stagOk = !stag_r || stagCnt_r == `CCM_STAG_LAST;

   // Global control
   always_ff @(posedge clk) begin
      if (reset) stag_r <= 1'b0;
      else if (wrHit(busReq, `CCM_GCTRL)) stag_r <= busReq.wdata[`CCM_GCTL_STAG];
   end

   // ---------------------------------------------------------------
   // Time bases
   // ---------------------------------------------------------------
   for (genvar t = 0; t < 2; t++) begin : g_tmr
      localparam logic [5:0] BASE = 6'(`CCM_TMR_BASE + t * `CCM_TMR_STRIDE);
      logic [2:0] sel;
      logic [7:0] pmask;
      assign sel   = tmrCtl_r[t][`CCM_TCTL_CLK +: 3];
      assign pmask = 8'((9'h001 << sel) - 9'h001);
      always_comb begin
         case (sel)
            `CCM_CLK_T6:  tmrTick[t] = genTimerSixOvf;
            `CCM_CLK_EXT: tmrTick[t] = extCount[t] && !extPrev_r[t];
            default:      tmrTick[t] = stagOk && (presc_r & pmask) == pmask;
         endcase
      end
      // Control and reload registers
      always_ff @(posedge clk) begin
         if (reset) begin
            tmrCtl_r[t]  <= 4'h0;
            tmrRel_r[t]  <= `CCM_RST_WORD;
            extPrev_r[t] <= 1'b0;
         end else begin
            extPrev_r[t] <= extCount[t];
            if (wrHit(busReq, BASE + `CCM_TMR_CTRL)) tmrCtl_r[t] <= busReq.wdata[3:0];
            if (wrHit(busReq, BASE + `CCM_TMR_REL)) tmrRel_r[t] <= busReq.wdata;
         end
      end
      always_ff @(posedge clk) begin
         if (reset) begin
            tmrCnt_r[t]  <= `CCM_RST_WORD;
            tmrStep_r[t] <= 1'b0;
            ovf_r[t]     <= 1'b0;
         end else begin
            tmrStep_r[t] <= 1'b0;
            ovf_r[t]     <= 1'b0;
            if (wrHit(busReq, BASE + `CCM_TMR_CNT)) begin
               tmrCnt_r[t]  <= busReq.wdata;
               tmrStep_r[t] <= 1'b1;
            end else if (tmrCtl_r[t][`CCM_TCTL_RUN] && tmrTick[t]) begin
               tmrStep_r[t] <= 1'b1;
               if (tmrCnt_r[t] == `CCM_CNT_TOP) begin
                  tmrCnt_r[t] <= tmrRel_r[t];
                  ovf_r[t]    <= 1'b1;
               end else begin
                  tmrCnt_r[t] <= tmrCnt_r[t] + 16'h0001;
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Channels
   // ---------------------------------------------------------------
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      ccm_pkg::ccm_mode_t m;
      logic tb, rise, fall, once, partner, isCmp;
      assign m     = cfg_r[i].mode;
      assign tb    = cfg_r[i].tsel;
      assign isCmp = m[2];
      assign chCnt[i] = tmrCnt_r[tb];
      assign rise     = pinIn[i] && !pinPrev_r[i];
      assign fall     = !pinIn[i] && pinPrev_r[i];
      assign once     = m == ccm_pkg::CCM_CMP2 || m == ccm_pkg::CCM_CMP3;
      assign capEvt[i] = (m == ccm_pkg::CCM_CAP_RISE && rise) || (m == ccm_pkg::CCM_CAP_FALL && fall)
                       || (m == ccm_pkg::CCM_CAP_BOTH && (rise || fall));
      // match on each new timer value
      assign cmpMatch[i] = isCmp && tmrStep_r[tb] && chCnt[i] == ccVal_r[i] && (armed_r[i] || !once);
      if (i < NCH / 2) begin : g_dbl
         assign partner = cfg_r[i].dbl && cmpMatch[i + NCH / 2];
      end else begin : g_nodbl
         assign partner = 1'b0;
      end

      // Configuration; single event turns channel off
      always_ff @(posedge clk) begin
         if (reset) cfg_r[i] <= `CCM_RST_CFG;
         else if (wrHit(busReq, `CCM_MODE_BASE + 6'(i))) cfg_r[i] <= busReq.wdata[5:0];
         else if (cfg_r[i].single && (capEvt[i] || cmpMatch[i])) cfg_r[i].mode <= ccm_pkg::CCM_OFF;
      end

      // capture latch wins over software write
      always_ff @(posedge clk) begin
         if (reset) ccVal_r[i] <= `CCM_RST_WORD;
         else if (capEvt[i]) ccVal_r[i] <= chCnt[i];
         else if (wrHit(busReq, `CCM_CC_BASE + 6'(i))) ccVal_r[i] <= busReq.wdata;
      end

      always_ff @(posedge clk) begin
         if (reset) armed_r[i] <= 1'b1;
         else if (ovf_r[tb] || wrHit(busReq, `CCM_MODE_BASE + 6'(i))) armed_r[i] <= 1'b1;
         else if (cmpMatch[i] && once) armed_r[i] <= 1'b0;
      end

      always_ff @(posedge clk) begin
         if (reset) begin
            pinPrev_r[i] <= 1'b0;
            pinOut_r[i]  <= 1'b0;
            pinOe_r[i]   <= 1'b0;
         end else begin
            pinPrev_r[i] <= pinIn[i];
            pinOe_r[i]   <= m == ccm_pkg::CCM_CMP1 || m == ccm_pkg::CCM_CMP3 || partner
                            || (i < NCH / 2 && cfg_r[i].dbl);
            if (m == ccm_pkg::CCM_CMP3 && cmpMatch[i]) pinOut_r[i] <= 1'b1;
            else if (m == ccm_pkg::CCM_CMP3 && ovf_r[tb]) pinOut_r[i] <= 1'b0;
            else if ((m == ccm_pkg::CCM_CMP1 && cmpMatch[i]) || partner) pinOut_r[i] <= !pinOut_r[i];
         end
      end
   end

   // ---------------------------------------------------------------
   // Interrupts
   // ---------------------------------------------------------------
   assign irqClr = wrHit(busReq, `CCM_IRQ_STAT) ? busReq.wdata[NCH-1:0] : '0;
   // events set status, set wins over clear
   always_ff @(posedge clk) begin
      if (reset) begin
         irqStat_r <= '0;
         irqMask_r <= '0;
         irq_r     <= 1'b0;
      end else begin
         irqStat_r <= (irqStat_r & ~irqClr) | capEvt | cmpMatch;
         if (wrHit(busReq, `CCM_IRQ_MASK)) irqMask_r <= busReq.wdata[NCH-1:0];
         irq_r <= |(irqStat_r & irqMask_r);
      end
   end

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   // Read decode, unmapped reads return zero
   always_comb begin
      rdata_nxt = `CCM_RST_WORD;
      case (busReq.addr)
         `CCM_GCTRL:    rdata_nxt = {15'h0000, stag_r};
         `CCM_IRQ_STAT: rdata_nxt = 16'(irqStat_r);
         `CCM_IRQ_MASK: rdata_nxt = 16'(irqMask_r);
         `CCM_PIN_STAT: rdata_nxt = 16'(pinOut_r);
         6'h20:         rdata_nxt = {12'h000, tmrCtl_r[0]};
         6'h21:         rdata_nxt = tmrCnt_r[0];
         6'h22:         rdata_nxt = tmrRel_r[0];
         6'h23:         rdata_nxt = {12'h000, tmrCtl_r[1]};
         6'h24:         rdata_nxt = tmrCnt_r[1];
         6'h25:         rdata_nxt = tmrRel_r[1];
         default: begin
            if (busReq.addr < 6'(NCH)) rdata_nxt = ccVal_r[busReq.addr[3:0]];
            else if (busReq.addr >= `CCM_MODE_BASE && busReq.addr < `CCM_MODE_BASE + 6'(NCH))
               rdata_nxt = {10'h000, cfg_r[busReq.addr[3:0]]};
         end
      endcase
   end

   // Registered read data, valid only after a read strobe
   always_ff @(posedge clk) begin
      if (reset) rdata_r <= `CCM_RST_WORD;
      else rdata_r <= busReq.rd ? rdata_nxt : `CCM_RST_WORD;
   end

   assign rdata  = rdata_r;
   assign pinOut = pinOut_r;
   assign pinOe  = pinOe_r;
   assign irq    = irq_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // ---------------------------------------------------------------
   // Capture checks
   // ---------------------------------------------------------------
   // capture latches timer
   a_capture_latch: assert property (capEvt[1] |=> ccVal_r[1] == $past(chCnt[1]))
      else $error("capture did not latch timer");

   a_capture_irq: assert property (capEvt[1] ##1 irqMask_r[1] |=> irq)
      else $error("capture did not raise interrupt");

   a_capture_status: assert property (capEvt[1] |=> irqStat_r[1])
      else $error("capture did not set status");

   a_edge_select: assert property (cfg_r[1].mode == ccm_pkg::CCM_CAP_RISE && !pinIn[1] |-> !capEvt[1])
      else $error("capture on wrong edge");

   // ---------------------------------------------------------------
   // Compare checks
   // ---------------------------------------------------------------
   // mode 0 leaves pin alone
   a_cmp0_quiet: assert property (cfg_r[4].mode == ccm_pkg::CCM_CMP0 && !cfg_r[4].dbl
      |=> pinOut_r[4] == $past(pinOut_r[4]))
      else $error("mode 0 moved the pin");

   a_mode_one_toggle: assert property (cfg_r[6].mode == ccm_pkg::CCM_CMP1 && !cfg_r[6].dbl && cmpMatch[6]
      |=> pinOut_r[6] != $past(pinOut_r[6]))
      else $error("mode 1 pin did not toggle");

   a_mode_three_set: assert property (cfg_r[7].mode == ccm_pkg::CCM_CMP3 && cmpMatch[7] |=> pinOut_r[7])
      else $error("mode 3 pin not set on match");

   a_mode_three_clear: assert property (cfg_r[7].mode == ccm_pkg::CCM_CMP3 && ovf_r[cfg_r[7].tsel]
      && !cmpMatch[7] |=> !pinOut_r[7])
      else $error("mode 3 pin not cleared on overflow");

   a_pin_drive: assert property (cfg_r[7].mode == ccm_pkg::CCM_CMP3 |=> pinOe_r[7])
      else $error("compare pin not driven");

   a_mode_two_once: assert property (cfg_r[5].mode == ccm_pkg::CCM_CMP2 && cmpMatch[5]
      && !ovf_r[cfg_r[5].tsel] && !wrHit(busReq, `CCM_MODE_BASE + 6'h05) |=> !cmpMatch[5] [*2])
      else $error("mode 2 matched twice in a period");

   a_rearm: assert property (ovf_r[0] && !cfg_r[7].tsel |=> armed_r[7])
      else $error("overflow did not rearm channel");

   a_double_toggle: assert property (cfg_r[0].dbl && cmpMatch[8] && cfg_r[0].mode != ccm_pkg::CCM_CMP3
      && !(cfg_r[0].mode == ccm_pkg::CCM_CMP1 && cmpMatch[0]) |=> pinOut_r[0] != $past(pinOut_r[0]))
      else $error("double mode pin did not toggle");

   a_single_off: assert property (cfg_r[8].single && cmpMatch[8] && !wrHit(busReq, `CCM_MODE_BASE + 6'h08)
      |=> cfg_r[8].mode == ccm_pkg::CCM_OFF)
      else $error("single event left channel on");

   a_match_irq: assert property (cmpMatch[6] |=> irqStat_r[6])
      else $error("match did not set status");

   a_irq_level: assert property (|(irqStat_r & irqMask_r) |=> irq)
      else $error("interrupt output missing");

   // ---------------------------------------------------------------
   // Timer and bus checks
   // ---------------------------------------------------------------
   // timer counts up by one
   a_timer_step: assert property (tmrCtl_r[1][`CCM_TCTL_RUN] && tmrTick[1] && tmrCnt_r[1] != `CCM_CNT_TOP
      && !wrHit(busReq, `CCM_TMR_BASE + `CCM_TMR_STRIDE + `CCM_TMR_CNT)
      |=> tmrCnt_r[1] == $past(tmrCnt_r[1]) + 16'h0001)
      else $error("timer did not step by one");

   a_reload_wrap: assert property (tmrCtl_r[0][`CCM_TCTL_RUN] && tmrTick[0] && tmrCnt_r[0] == `CCM_CNT_TOP
      && !wrHit(busReq, `CCM_TMR_BASE + `CCM_TMR_CNT) |=> tmrCnt_r[0] == $past(tmrRel_r[0]) && ovf_r[0])
      else $error("timer did not reload on overflow");

   a_t6_clock: assert property (tmrCtl_r[1][`CCM_TCTL_CLK +: 3] == `CCM_CLK_T6
      |-> tmrTick[1] == genTimerSixOvf)
      else $error("timer-six clock not followed");

   a_ext_clock: assert property (tmrCtl_r[1][`CCM_TCTL_CLK +: 3] == `CCM_CLK_EXT && extCount[1]
      && !$past(extCount[1]) |-> tmrTick[1])
      else $error("external edge did not tick");

   a_stagger_slot: assert property (stag_r && tmrTick[0] && tmrCtl_r[0][`CCM_TCTL_CLK +: 3] < `CCM_CLK_T6
      |-> stagCnt_r == `CCM_STAG_LAST)
      else $error("staggered timer stepped off slot");

   a_read_idle: assert property (!busReq.rd |=> rdata == 16'h0000)
      else $error("read data not zero when idle");

   // ---------------------------------------------------------------
   // Cover points
   // ---------------------------------------------------------------
   c_capture: cover property (capEvt[1] ##1 irqStat_r[1]);
   c_mode_three: cover property (cmpMatch[7] ##[1:200] ovf_r[0]);
   c_overflow: cover property (ovf_r[1]);
   c_double: cover property (cfg_r[0].dbl && cmpMatch[8]);
   c_single: cover property (cfg_r[8].single && cmpMatch[8]);
endmodule
`default_nettype wire

// file: verification/ccm_pins.sv
// Far-side pin model: resolves channel pins and passes count events
`timescale 1ns/1ps
`default_nettype none
module ccm_pins #(
   parameter int NCH = 16                 // Channel count
) (
   input  wire logic [NCH-1:0] pinOut,    // Unit drive level
   input  wire logic [NCH-1:0] pinOe,     // Unit drive enable
   input  wire logic [NCH-1:0] extLvl,    // Outside source level
   input  wire logic [1:0]     extEv,     // Outside count events
   output logic      [NCH-1:0] pinIn,     // Resolved pin level
   output logic      [1:0]     extCount   // Count inputs to unit
);
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         pinIn[i] = pinOe[i] ? pinOut[i] : extLvl[i];
      end
   end
   assign extCount = extEv;
endmodule
`default_nettype wire

// file: verification/tb_ccm_unit.sv
// Self-checking bench for the capture/compare unit
`timescale 1ns/1ps
`default_nettype none
`include "ccm_regs.svh"
module tb_ccm_unit;
   localparam logic [5:0] T0 = `CCM_TMR_BASE;
   localparam logic [5:0] T1 = `CCM_TMR_BASE + `CCM_TMR_STRIDE;
   localparam logic [5:0] ST = `CCM_IRQ_STAT;
   localparam logic [5:0] MB = `CCM_MODE_BASE;
   localparam logic [5:0] CB = `CCM_CC_BASE;
   logic                  clk = 1'b0;
   logic                  reset = 1'b1;
   ccm_pkg::ccm_bus_req_t busReq = '0;
   logic [15:0]           rdata, pinOut, pinOe, pinIn, rd;
   logic [15:0]           extLvl = 16'h0000;
   logic [1:0]            extEv = 2'h0;
   logic [1:0]            extCount;
   logic                  t6Ovf = 1'b0;
   logic                  irq;
   int                    error_cnt = 0;
   int                    samples_checked = 0;

   always #12.5 clk = ~clk;

   ccm_unit uut (.clk(clk), .reset(reset), .busReq(busReq), .rdata(rdata), .pinIn(pinIn),
      .pinOut(pinOut), .pinOe(pinOe), .genTimerSixOvf(t6Ovf), .extCount(extCount), .irq(irq));
   ccm_pins far (.pinOut(pinOut), .pinOe(pinOe), .extLvl(extLvl), .extEv(extEv),
      .pinIn(pinIn), .extCount(extCount));

   // ----------
   // Bus tasks
   // ----------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      busReq.wr <= 1'b0;
   endtask
   task automatic rdreg(input logic [5:0] a, output logic [15:0] d);
      @(posedge clk);
      busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      busReq.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic chkRd(input logic [5:0] a, input logic [15:0] exp, input string m);
      rdreg(a, rd);
      chk(rd, exp, m);
   endtask
   task automatic waitPin(input int i, input logic v, input int n);
      for (int k = 0; k < n && pinOut[i] !== v; k++) begin
         @(posedge clk);
         #1;
      end
      chk(16'(pinOut[i] === v), 16'h0001, "pin wait");
   endtask
   task automatic test_done;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ----------
   // Scenarios
   // ----------
   task automatic t_reset;
      chkRd(ST, 16'h0000, "status rst");
      chkRd(`CCM_PIN_STAT, 16'h0000, "pins rst");
      chkRd(6'h3F, 16'h0000, "unmapped");
      chk(16'(irq), 16'h0000, "irq rst");
   endtask
   task automatic t_capture;
      wr(T1 + `CCM_TMR_CNT, 16'h4321);
      wr(T0 + `CCM_TMR_CNT, 16'h1234);
      for (int m = 1; m <= 3; m++) begin
         wr(MB + 6'(m), {12'h000, 1'(m == 3), 3'(m)});
         extLvl[m] <= 1'b1;
         tick(4);
         rdreg(ST, rd);
         chk(16'(rd[m]), 16'(m != 2), "rise cap");
         wr(ST, 16'hFFFF);
         extLvl[m] <= 1'b0;
         tick(4);
         rdreg(ST, rd);
         chk(16'(rd[m]), 16'(m != 1), "fall cap");
         wr(ST, 16'hFFFF);
         chkRd(CB + 6'(m), (m == 3) ? 16'h4321 : 16'h1234, "cap val");
      end
      extLvl[1] <= 1'b1;
      tick(4);
      chk(16'(irq), 16'h0000, "irq masked");
      wr(`CCM_IRQ_MASK, 16'h0002);
      tick(2);
      chk(16'(irq), 16'h0001, "irq on");
      wr(ST, 16'hFFFF);
      tick(2);
      chk(16'(irq), 16'h0000, "irq clr");
   endtask
   task automatic t_cmp02;
      wr(MB + 6'h04, 16'h0004);
      wr(CB + 6'h04, 16'h00A0);
      wr(MB + 6'h05, 16'h0006);
      wr(CB + 6'h05, 16'h00A0);
      for (int k = 0; k < 2; k++) begin
         wr(T0 + `CCM_TMR_CNT, 16'h00A0);
         tick(3);
         chkRd(ST, k ? 16'h0010 : 16'h0030, "cmp0/2 irq");
         wr(ST, 16'hFFFF);
      end
      chk(pinOe & 16'h0030, 16'h0000, "pin untouched");
   endtask
   task automatic t_toggle;
      wr(MB + 6'h06, 16'h0005);
      wr(CB + 6'h06, 16'h0050);
      for (int k = 0; k < 2; k++) begin
         wr(T0 + `CCM_TMR_CNT, 16'h0050);
         tick(3);
         chk(16'(pinOut[6]), 16'(k == 0), "toggle");
         chkRd(ST, 16'h0040, "cmp1 irq");
         wr(ST, 16'hFFFF);
      end
      chk(16'(pinOe[6]), 16'h0001, "toggle oe");
      wr(MB + 6'h08, 16'h0014);
      wr(CB + 6'h08, 16'h0033);
      for (int k = 0; k < 2; k++) begin
         wr(T0 + `CCM_TMR_CNT, 16'h0033);
         tick(3);
         chkRd(ST, k ? 16'h0000 : 16'h0100, "single");
         wr(ST, 16'hFFFF);
      end
      wr(MB + 6'h00, 16'h0025);
      wr(CB + 6'h00, 16'h0011);
      wr(MB + 6'h08, 16'h0004);
      wr(CB + 6'h08, 16'h0022);
      wr(T0 + `CCM_TMR_CNT, 16'h0011);
      tick(3);
      chk(16'(pinOut[0]), 16'h0001, "dbl first");
      wr(T0 + `CCM_TMR_CNT, 16'h0022);
      tick(3);
      chk(16'(pinOut[0]), 16'h0000, "dbl second");
   endtask
   task automatic t_mode3;
      wr(MB + 6'h07, 16'h0007);
      wr(CB + 6'h07, 16'hFFF8);
      wr(T0 + `CCM_TMR_REL, 16'hFFF0);
      wr(T0 + `CCM_TMR_CNT, 16'hFFF0);
      wr(T0, 16'h0001);
      waitPin(7, 1'b1, 24);
      waitPin(7, 1'b0, 16);
      waitPin(7, 1'b1, 16);
      wr(T0, 16'h0000);
   endtask
   task automatic t_clocks;
      logic [15:0] a;
      logic [15:0] b;
      wr(T1 + `CCM_TMR_CNT, 16'h0000);
      wr(T1, 16'h000F);
      repeat (3) begin
         extEv[1] <= 1'b1;
         tick(2);
         extEv[1] <= 1'b0;
         tick(2);
      end
      chkRd(T1 + `CCM_TMR_CNT, 16'h0003, "ext count");
      wr(T1, 16'h000D);
      repeat (2) begin
         t6Ovf <= 1'b1;
         tick(1);
         t6Ovf <= 1'b0;
         tick(2);
      end
      chkRd(T1 + `CCM_TMR_CNT, 16'h0005, "t6 count");
      for (int k = 0; k < 3; k++) begin
         wr(`CCM_GCTRL, 16'(k == 2));
         wr(T1, (k == 1) ? 16'h0005 : 16'h0001);
         rdreg(T1 + `CCM_TMR_CNT, a);
         tick(78);
         rdreg(T1 + `CCM_TMR_CNT, b);
         chk(b - a, (k == 0) ? 16'h0050 : (k == 1) ? 16'h0014 : 16'h000A, "rate");
      end
      wr(T1, 16'h0000);
   endtask

   initial begin
      #125000;
      error_cnt++;
      test_done();
   end
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_capture();
      t_cmp02();
      t_toggle();
      t_mode3();
      t_clocks();
      test_done();
   end
endmodule
`default_nettype wire
